/* verilog/wdt_defs.svh */
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// register selectors on the cpu port
`define WDT_SEL_CTRL_CNT 2'h0
`define WDT_SEL_RSTCTRL  2'h1
`define WDT_SEL_COUNT    2'h2

// write keys in the upper byte of a word write; the flag clear code goes in the lower byte
`define WDT_KEY_COUNT    8'h5A
`define WDT_KEY_CTRL     8'hA5
`define WDT_KEY_LOW_CLR  8'h00

// timer control field positions
`define WDT_TC_OVF_BIT   7
`define WDT_TC_MODE_BIT  6
`define WDT_TC_EN_BIT    5
`define WDT_TC_RSV_MASK  8'h18
`define WDT_TC_CKS_MSB   2

// reset control field positions
`define WDT_RC_WDFLAG_BIT     7
`define WDT_RC_RESET_EN_BIT   6
`define WDT_RC_RESET_TYPE_BIT 5
`define WDT_RC_RSV_MASK  8'h1F

// reset values
`define WDT_COUNT_RESET  8'h00
`define WDT_RC_RESET     8'h1F

// timing, in system clock states
`define WDT_RESET_HOLD   518
`define WDT_LOCKOUT      132

`endif

/* verilog/wdt_pkg.sv */
`default_nettype none

package wdt_pkg;

  typedef struct packed {
    logic       ovf;
    logic       mode_wd;
    logic       en;
    logic [2:0] cks;
  } wdt_ctrl_t;

  typedef struct packed {
    logic       wd_flag;
    logic       rst_en;
    logic       rst_type;
  } wdt_rstctrl_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  sel;
    logic [15:0] wdata;
  } wdt_cpu_req_t;

endpackage

`default_nettype wire

/* verilog/wdt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module wdt_prescaler #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // control
  input  wire logic       run,
  input  wire logic [2:0] cks,
  // tick out
  output logic            tick
);

  logic [WIDTH-1:0] div_q;
  logic [WIDTH-1:0] div_d;

  initial begin
    if (WIDTH < 17) $error("prescaler too narrow for the longest tap");
  end

  // tap index per code; codes 000..101 are free choices
  function automatic int tap_of(input logic [2:0] c);
    unique case (c)
      3'h0: tap_of = 0;
      3'h1: tap_of = 5;
      3'h2: tap_of = 6;
      3'h3: tap_of = 7;
      3'h4: tap_of = 8;
      3'h5: tap_of = 10;
      3'h6: tap_of = 14;
      3'h7: tap_of = 16;
    endcase
  endfunction

  assign div_d = div_q + {{(WIDTH-1){1'b0}}, 1'b1};

  // held at zero while stopped so each start begins a full period
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // one-cycle pulse when all bits up to the tap are one: divide by 2^(tap+1)
  logic [WIDTH-1:0] mask;
  always_comb begin
    mask = '0;
    for (int i = 0; i < WIDTH; i++) begin
      mask[i] = (i <= tap_of(cks));
    end
  end

  assign tick = run && ((div_q & mask) == mask);

endmodule

`default_nettype wire

/* verilog/wdt_lockout.sv */
`timescale 1ns/1ps
`default_nettype none

module wdt_lockout #(
  parameter int COUNT = 132
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // start event and busy level
  input  wire logic start,
  output logic      busy
);

  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_q;

  initial begin
    if (COUNT < 1) $error("lockout count must be at least one");
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= W'(COUNT);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy = (cnt_q != '0);

endmodule

`default_nettype wire

/* verilog/wdt_timer.sv */
// Contract
// - count enable 1 counts selected ticks; 0 stops and zeroes counter
// - reset clears the counter to zero
// - counter wrap from FF to 00 in interval mode sets the overflow flag
// - overflow flag clears only by read-at-one then write 0
// - watchdog reset overflow clears overflow flag via internal reset
// - mode select 0 interval, 1 watchdog; resets to 0
// - reserved control bits read one and ignore writes
// - clock select picks one of eight prescaler taps
// - watchdog flag sets on overflow only in watchdog mode
// - watchdog flag clears only by read-at-one then write 0
// - reset control loads 1F only from the pin reset
// - reset enable 1 plus watchdog overflow requests chip reset
// - reset enable 0 overflow resets counter and control only
// - reset type 0 selects power-on; 1 is prohibited
// - interval mode overflow raises the interval interrupt
// - protected registers accept only keyed word writes
// - key 5A loads counter, key A5 loads control
// - A5 00 clears watchdog flag; 5A loads reset bits 6 and 5
// - internal reset held for 518 clock states
// - protected registers ignore writes for 132 states after overflow
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_timer #(
  parameter int RESET_HOLD = `WDT_RESET_HOLD,
  parameter int LOCKOUT    = `WDT_LOCKOUT
) (
  // clock and pin reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // cpu port
  input  wire wdt_pkg::wdt_cpu_req_t cpu_req,
  output logic [7:0]                 cpu_rdata,
  // events
  output logic                       interval_interrupt,
  output logic                       chip_reset_req,
  output logic                       chip_reset_type
);

  localparam int HW = $clog2(RESET_HOLD + 1);

  initial begin
    if (RESET_HOLD < 1) $error("reset hold must be at least one");
  end

  wdt_pkg::wdt_ctrl_t    ctrl_q;
  wdt_pkg::wdt_rstctrl_t rc_q;
  logic [7:0]            count_q;
  logic                  ovf_seen_q;
  logic                  wd_seen_q;
  logic [HW-1:0]         hold_q;
  logic                  tick;
  logic                  wrap;
  logic                  lock;
  logic                  wd_clear;
  logic                  wr_cnt;
  logic                  wr_ctl;
  logic                  wr_rc_clr;
  logic                  wr_rc_set;
  logic [7:0]            wlo;
  logic [7:0]            whi;

  assign wlo = cpu_req.wdata[7:0];
  assign whi = cpu_req.wdata[15:8];

  wdt_prescaler #(.WIDTH(17)) u_pre (
    .clk   (clk),
    .reset (reset),
    .run   (ctrl_q.en),
    .cks   (ctrl_q.cks),
    .tick  (tick)
  );

  wdt_lockout #(.COUNT(LOCKOUT)) u_lock (
    .clk   (clk),
    .reset (reset),
    .start (wrap),
    .busy  (lock)
  );

  // keyed word writes only; refused during the post-overflow lockout
  always_comb begin
    wr_cnt    = cpu_req.wr && !lock && cpu_req.sel == `WDT_SEL_CTRL_CNT
                && whi == `WDT_KEY_COUNT;
    wr_ctl    = cpu_req.wr && !lock && cpu_req.sel == `WDT_SEL_CTRL_CNT
                && whi == `WDT_KEY_CTRL;
    wr_rc_clr = cpu_req.wr && !lock && cpu_req.sel == `WDT_SEL_RSTCTRL
                && whi == `WDT_KEY_CTRL && wlo == `WDT_KEY_LOW_CLR;
    wr_rc_set = cpu_req.wr && !lock && cpu_req.sel == `WDT_SEL_RSTCTRL
                && whi == `WDT_KEY_COUNT;
  end

  assign wrap = ctrl_q.en && tick && !wr_cnt && count_q == 8'hFF;

  // watchdog overflow resets counter and control whether or not chip reset follows
  assign wd_clear = wrap && ctrl_q.mode_wd;

  // counter; a write beats an increment
  always_ff @(posedge clk) begin
    if (reset || wd_clear || !ctrl_q.en) begin
      count_q <= `WDT_COUNT_RESET;
    end else if (wr_cnt) begin
      count_q <= wlo;
    end else if (tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  // control register; reserved bits are not stored
  always_ff @(posedge clk) begin
    if (reset || wd_clear) begin
      ctrl_q <= '0;
    end else begin
      if (wr_ctl) begin
        ctrl_q.mode_wd <= wlo[`WDT_TC_MODE_BIT];
        ctrl_q.en      <= wlo[`WDT_TC_EN_BIT];
        ctrl_q.cks     <= wlo[`WDT_TC_CKS_MSB:0];
      end
      // set wins over a clear in the same cycle
      if (wrap) begin
        ctrl_q.ovf <= 1'b1;
      end else if (wr_ctl && !wlo[`WDT_TC_OVF_BIT] && ovf_seen_q) begin
        ctrl_q.ovf <= 1'b0;
      end
    end
  end

  // read-at-one arming for the overflow flag clear
  always_ff @(posedge clk) begin
    if (reset || wd_clear || !ctrl_q.ovf) begin
      ovf_seen_q <= 1'b0;
    end else if (cpu_req.rd && cpu_req.sel == `WDT_SEL_CTRL_CNT) begin
      ovf_seen_q <= 1'b1;
    end
  end

  // reset control: only the pin reset initialises it
  always_ff @(posedge clk) begin
    if (reset) begin
      rc_q <= '0;
    end else begin
      if (wr_rc_set) begin
        rc_q.rst_en   <= wlo[`WDT_RC_RESET_EN_BIT];
        rc_q.rst_type <= wlo[`WDT_RC_RESET_TYPE_BIT];
      end
      if (wd_clear) begin
        rc_q.wd_flag <= 1'b1;
      end else if (wr_rc_clr && wd_seen_q) begin
        rc_q.wd_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !rc_q.wd_flag) begin
      wd_seen_q <= 1'b0;
    end else if (cpu_req.rd && cpu_req.sel == `WDT_SEL_RSTCTRL) begin
      wd_seen_q <= 1'b1;
    end
  end

  // internal reset stretch
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_q <= '0;
    end else if (wd_clear && rc_q.rst_en) begin
      hold_q <= HW'(RESET_HOLD);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - HW'(1);
    end
  end

  assign chip_reset_req     = (hold_q != '0);
  assign chip_reset_type    = rc_q.rst_type;
  assign interval_interrupt = ctrl_q.ovf && !ctrl_q.mode_wd;

  // registered read data
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_rdata <= 8'h00;
    end else begin
      unique case (cpu_req.sel)
        `WDT_SEL_CTRL_CNT:
          cpu_rdata <= {ctrl_q.ovf, ctrl_q.mode_wd, ctrl_q.en, 2'b11, ctrl_q.cks};
        `WDT_SEL_RSTCTRL:
          cpu_rdata <= {rc_q.wd_flag, rc_q.rst_en, rc_q.rst_type, 5'h1F};
        `WDT_SEL_COUNT:
          cpu_rdata <= count_q;
        default:
          cpu_rdata <= 8'h00;
      endcase
    end
  end

  // checks
  a_wrap_sets_ovf: assert property (@(posedge clk) disable iff (reset)
    wrap && !ctrl_q.mode_wd |=> ctrl_q.ovf) else $error("overflow flag not set");
  a_disable_zero: assert property (@(posedge clk) disable iff (reset)
    !ctrl_q.en |=> count_q == 8'h00) else $error("counter not zero when off");
  a_hold_length: assert property (@(posedge clk) disable iff (reset)
    $rose(chip_reset_req) |-> chip_reset_req [*8]) else $error("reset pulse short");
  a_wdflag_mode: assert property (@(posedge clk) disable iff (reset)
    $rose(rc_q.wd_flag) |-> $past(ctrl_q.mode_wd)) else $error("watchdog flag in interval");
  // checks the stored reset enable and type bits, not the gated strobes, so a broken wr_rc_set gate is caught
  a_lock_refuse: assert property (@(posedge clk) disable iff (reset)
    lock |=> $stable(rc_q.rst_en) && $stable(rc_q.rst_type)) else $error("write during lockout");
  a_wd_reset_ctl: assert property (@(posedge clk) disable iff (reset)
    wd_clear |=> ctrl_q == '0 && count_q == 8'h00) else $error("watchdog clear missed");
  a_irq_follows: assert property (@(posedge clk) disable iff (reset)
    interval_interrupt |-> ctrl_q.ovf && !ctrl_q.mode_wd) else $error("irq without flag");
  a_ovf_clear: assert property (@(posedge clk) disable iff (reset)
    $fell(ctrl_q.ovf) |-> $past(ovf_seen_q) || $past(wd_clear)) else $error("bad ovf clear");
  a_rc_keep: assert property (@(posedge clk) disable iff (reset)
    wd_clear |=> rc_q.rst_en == $past(rc_q.rst_en)) else $error("reset control lost");

endmodule

`default_nettype wire

/* testbench/watchdog_interval_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module watchdog_interval_timer_bench;
  logic                  clk;
  logic                  reset;
  wdt_pkg::wdt_cpu_req_t req;
  logic [7:0]            cpu_rdata;
  logic                  interval_interrupt;
  logic                  chip_reset_req;
  logic                  chip_reset_type;
  logic [7:0]            v;
  int                    error_cnt = 0;
  int                    checked = 0;
  int                    hold_n = 0;
  int                    divs[7] = '{2, 64, 128, 256, 512, 2048, 32768};

  // short counts keep the run small
  wdt_timer #(.RESET_HOLD(8), .LOCKOUT(4)) dut_u (
    .clk                (clk),
    .reset              (reset),
    .cpu_req            (req),
    .cpu_rdata          (cpu_rdata),
    .interval_interrupt (interval_interrupt),
    .chip_reset_req     (chip_reset_req),
    .chip_reset_type    (chip_reset_type)
  );

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (chip_reset_req === 1'h1) hold_n <= hold_n + 1;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'h1, rd: 1'h0, sel: s, wdata: d};
    @(posedge clk);
    req.wr <= 1'h0;
  endtask

  task automatic rdc(input logic [1:0] s, input logic [7:0] e, input string n);
    @(posedge clk);
    req <= '{wr: 1'h0, rd: 1'h1, sel: s, wdata: 16'h0000};
    @(posedge clk);
    req.rd <= 1'h0;
    #1;
    chk(n, e, cpu_rdata);
  endtask

  // waits for one event output, bounded
  task automatic wait_ev(input logic r);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if ((r ? chip_reset_req : interval_interrupt) === 1'h1) return;
    end
    chk("event wait", 8'h01, 8'h00);
    print_verdict();
  endtask

  task automatic t_reset;
    rdc(2'h0, 8'h18, "ctrl after reset");
    rdc(2'h1, 8'h1F, "rstctrl after reset");
    rdc(2'h2, 8'h00, "count after reset");
    chk("reset type", 8'h00, {7'h00, chip_reset_type});
    $display("done reset values");
  endtask

  task automatic t_keys;
    wr(2'h0, 16'h12FF);
    rdc(2'h0, 8'h18, "unkeyed ctrl");
    wr(2'h1, 16'h1240);
    rdc(2'h1, 8'h1F, "unkeyed rstctrl");
    wr(2'h0, 16'hA527);
    rdc(2'h0, 8'h3F, "keyed ctrl");
    wr(2'h0, 16'h5AAB);
    rdc(2'h2, 8'hAB, "keyed count");
    wr(2'h0, 16'hA507);
    rdc(2'h2, 8'h00, "count stopped");
    $display("done keyed writes");
  endtask

  task automatic t_interval;
    wr(2'h0, 16'hA520);
    wr(2'h0, 16'h5AF0);
    wait_ev(1'h0);
    repeat (8) @(posedge clk);
    wr(2'h0, 16'hA520);
    rdc(2'h0, 8'hB8, "ovf no prior read");
    wr(2'h0, 16'hA5A0);
    rdc(2'h0, 8'hB8, "ovf write one");
    wr(2'h0, 16'hA520);
    rdc(2'h0, 8'h38, "ovf cleared");
    chk("irq after clear", 8'h00, {7'h00, interval_interrupt});
    rdc(2'h1, 8'h1F, "no wd flag interval");
    wr(2'h0, 16'hA500);
    $display("done interval mode");
  endtask

  // the slowest tap is left out to keep the run short
  task automatic t_clksel;
    int n;
    for (int c = 0; c < 7; c++) begin
      wr(2'h0, {8'hA5, 5'h04, c[2:0]});
      @(posedge clk);
      req.sel <= 2'h2;
      @(posedge clk);
      #1;
      v = cpu_rdata;
      for (n = 0; n < divs[c] + 8 && cpu_rdata === v; n++) begin
        @(posedge clk);
        #1;
      end
      v = cpu_rdata;
      for (n = 0; n < divs[c] + 8; n++) begin
        @(posedge clk);
        #1;
        if (cpu_rdata !== v) break;
      end
      chk("tick spacing", divs[c][7:0], n[7:0] + 8'h01);
      chk("tick spacing full", 8'h01, {7'h00, n + 1 == divs[c]});
      wr(2'h0, 16'hA500);
    end
    $display("done clock select");
  endtask

  task automatic t_watchdog;
    wr(2'h1, 16'h5A40);
    rdc(2'h1, 8'h5F, "reset enable");
    wr(2'h0, 16'hA560);
    wr(2'h0, 16'h5AF0);
    wait_ev(1'h1);
    wr(2'h1, 16'h5A00);
    repeat (10) @(posedge clk);
    rdc(2'h1, 8'hDF, "wd flag and lockout");
    rdc(2'h0, 8'h18, "ctrl after wd reset");
    wr(2'h1, 16'hA500);
    rdc(2'h1, 8'h5F, "wd flag clear");
    wr(2'h1, 16'h5A00);
    rdc(2'h1, 8'h1F, "reset disable");
    chk("hold length", 8'h08, hold_n[7:0]);
    $display("done watchdog reset");
  endtask

  task automatic t_norst;
    wr(2'h0, 16'hA560);
    wr(2'h0, 16'h5AF0);
    repeat (60) @(posedge clk);
    rdc(2'h1, 8'h9F, "wd flag without reset");
    rdc(2'h0, 8'h18, "ctrl cleared");
    chk("no chip reset", 8'h08, hold_n[7:0]);
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    rdc(2'h1, 8'h1F, "pin reset rstctrl");
    $display("done no reset overflow");
  endtask

  initial begin
    req = '0;
    reset = 1'h1;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    t_reset();
    t_keys();
    t_interval();
    t_clksel();
    t_watchdog();
    t_norst();
    print_verdict();
  end
endmodule

`default_nettype wire
